// file: rtl/djp_pkg.sv
package djp_pkg;
   // ***************************************************
   // Link structure
   // ***************************************************
   localparam int unsigned CORES    = 2;
   localparam int unsigned IR_W     = 4;
   localparam int unsigned DR_W     = 32;
   localparam int unsigned CTRL_W   = 8;
   // ***************************************************
   // Instruction codes and capture values
   // ***************************************************
   localparam logic [3:0]  OP_IDCODE  = 4'h1;
   localparam logic [3:0]  OP_CTRL    = 4'h8;
   localparam logic [3:0]  OP_BYPASS  = 4'hF;
   localparam logic [3:0]  IR_CAPTURE = 4'h1;
   // Arbitrary identification values, one per core link
   localparam logic [31:0] ID_CORE0   = 32'h0000_1001;
   localparam logic [31:0] ID_CORE1   = 32'h0000_2001;
   // ***************************************************
   // Synchroniser map and reset values
   // ***************************************************
   localparam int unsigned SY_EVT     = 0;
   localparam int unsigned SY_HRST    = 1;
   localparam int unsigned SY_CTRL    = 2;
   localparam int unsigned SY_PER     = 4;
   localparam int unsigned SY_W       = SY_CTRL + SY_PER * CORES;
   localparam logic [9:0]  SY_RST     = 10'h002;
   localparam logic [1:0]  RST_SYNC   = 2'h0;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int unsigned CLK_NS     = 5;
   localparam int unsigned TRIG_NS    = 40;
   localparam int unsigned TRIG_CYC   = (TRIG_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0]  TRIG_LOAD  = 4'(TRIG_CYC);
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } djp_state_type;
   typedef struct packed {
      logic [3:0] spare;
      logic       hard_reset_n_req;
      logic       trig_en;
      logic       resume_req;
      logic       halt_req;
   } djp_ctrl_type;
   typedef struct packed {
      logic [5:0] spare;
      logic       hard_reset_n_seen;
      logic       debug_mode;
   } djp_stat_type;
endpackage

// file: rtl/djp_tap.sv
`timescale 1ns/1ps
module djp_tap #(
   parameter logic [31:0] ID = djp_pkg::ID_CORE0
) (
   input  wire logic                  tck_i,
   input  wire logic                  trst_n_i,
   input  wire logic                  tms_i,
   input  wire logic                  tdi_i,
   input  wire djp_pkg::djp_stat_type status_i,
   output djp_pkg::djp_ctrl_type      ctrl_o,
   output logic                       tdo_o,
   output logic                       tdo_oe_o,
   output logic                       byp_shift_o
);
   djp_pkg::djp_state_type state_q, state_d;
   logic [3:0]             ir_sh_q, ir_sh_d, ir_q, ir_d;
   logic [31:0]            dr_q, dr_d;
   djp_pkg::djp_ctrl_type  ctrl_q, ctrl_d;
   logic                   ser;
   logic                   shifting;

   // ***************************************************
   // Controller state and scan registers
   // ***************************************************
   // Next state follows the mode select line on each rising edge
   always_comb begin
      state_d = state_q;
      case (state_q)
         djp_pkg::TLR:    state_d = tms_i ? djp_pkg::TLR    : djp_pkg::RTI;
         djp_pkg::RTI:    state_d = tms_i ? djp_pkg::SEL_DR : djp_pkg::RTI;
         djp_pkg::SEL_DR: state_d = tms_i ? djp_pkg::SEL_IR : djp_pkg::CAP_DR;
         djp_pkg::CAP_DR: state_d = tms_i ? djp_pkg::EX1_DR : djp_pkg::SH_DR;
         djp_pkg::SH_DR:  state_d = tms_i ? djp_pkg::EX1_DR : djp_pkg::SH_DR;
         djp_pkg::EX1_DR: state_d = tms_i ? djp_pkg::UPD_DR : djp_pkg::PA_DR;
         djp_pkg::PA_DR:  state_d = tms_i ? djp_pkg::EX2_DR : djp_pkg::PA_DR;
         djp_pkg::EX2_DR: state_d = tms_i ? djp_pkg::UPD_DR : djp_pkg::SH_DR;
         djp_pkg::UPD_DR: state_d = tms_i ? djp_pkg::SEL_DR : djp_pkg::RTI;
         djp_pkg::SEL_IR: state_d = tms_i ? djp_pkg::TLR    : djp_pkg::CAP_IR;
         djp_pkg::CAP_IR: state_d = tms_i ? djp_pkg::EX1_IR : djp_pkg::SH_IR;
         djp_pkg::SH_IR:  state_d = tms_i ? djp_pkg::EX1_IR : djp_pkg::SH_IR;
         djp_pkg::EX1_IR: state_d = tms_i ? djp_pkg::UPD_IR : djp_pkg::PA_IR;
         djp_pkg::PA_IR:  state_d = tms_i ? djp_pkg::EX2_IR : djp_pkg::PA_IR;
         djp_pkg::EX2_IR: state_d = tms_i ? djp_pkg::UPD_IR : djp_pkg::SH_IR;
         djp_pkg::UPD_IR: state_d = tms_i ? djp_pkg::SEL_DR : djp_pkg::RTI;
         default:         state_d = djp_pkg::TLR;
      endcase
   end

   // Capture, shift and update; unknown codes behave as the one-bit bypass
   always_comb begin
      ir_sh_d = ir_sh_q;
      ir_d    = ir_q;
      dr_d    = dr_q;
      ctrl_d  = ctrl_q;
      case (state_q)
         djp_pkg::TLR: begin
            ir_d   = djp_pkg::OP_IDCODE;
            ctrl_d = '0;
         end
         djp_pkg::CAP_IR: ir_sh_d = djp_pkg::IR_CAPTURE;
         djp_pkg::SH_IR:  ir_sh_d = {tdi_i, ir_sh_q[3:1]};
         djp_pkg::UPD_IR: ir_d = ir_sh_q;
         djp_pkg::CAP_DR: begin
            if (ir_q == djp_pkg::OP_IDCODE) begin
               dr_d = ID;
            end else if (ir_q == djp_pkg::OP_CTRL) begin
               dr_d = {24'h000000, status_i};
            end else begin
               dr_d = 32'h00000000;
            end
         end
         djp_pkg::SH_DR: begin
            if (ir_q == djp_pkg::OP_IDCODE) begin
               dr_d = {tdi_i, dr_q[31:1]};
            end else if (ir_q == djp_pkg::OP_CTRL) begin
               dr_d = {24'h000000, tdi_i, dr_q[7:1]};
            end else begin
               dr_d = {31'h00000000, tdi_i};
            end
         end
         djp_pkg::UPD_DR: begin
            if (ir_q == djp_pkg::OP_CTRL) begin
               ctrl_d = dr_q[7:0];
            end
         end
         default: ;
      endcase
   end

   // Test reset acts at once, without waiting for the test clock
   always_ff @(posedge tck_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         state_q <= djp_pkg::TLR;
         ir_sh_q <= 4'h0;
         ir_q    <= djp_pkg::OP_IDCODE;
         dr_q    <= 32'h00000000;
         ctrl_q  <= '0;
      end else begin
         state_q <= state_d;
         ir_sh_q <= ir_sh_d;
         ir_q    <= ir_d;
         dr_q    <= dr_d;
         ctrl_q  <= ctrl_d;
      end
   end

   // ***************************************************
   // Serial output on the falling edge
   // ***************************************************
   // Half a cycle of hold for the next device, which samples on the rise
   assign ser      = (state_q == djp_pkg::SH_IR) ? ir_sh_q[0] : dr_q[0];
   assign shifting = (state_q == djp_pkg::SH_IR) || (state_q == djp_pkg::SH_DR);
   always_ff @(negedge tck_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else begin
         tdo_o    <= ser;
         tdo_oe_o <= shifting;
      end
   end

   assign ctrl_o      = ctrl_q;
   assign byp_shift_o = (state_q == djp_pkg::SH_DR) && (ir_q == djp_pkg::OP_BYPASS);

   // ***************************************************
   // Checks
   // ***************************************************
   sequence tms_five_s;
      tms_i [*5];
   endsequence
   tap_reset_a: assert property (@(posedge tck_i) disable iff (!trst_n_i)
      tms_five_s |=> state_q == djp_pkg::TLR) else $error("five TMS highs did not reset the controller");
   tap_trst_a: assert property (@(posedge tck_i)
      !trst_n_i |-> (state_q == djp_pkg::TLR && ir_q == djp_pkg::OP_IDCODE))
      else $error("controller not initialised under test reset");
   tdo_enable_a: assert property (@(posedge tck_i) disable iff (!trst_n_i)
      $past(trst_n_i) |-> tdo_oe_o == shifting) else $error("TDO enable does not follow shift states");
endmodule

// file: rtl/djp_top.sv
`timescale 1ns/1ps
// Behaviour
// - Test reset low initialises both test controllers at once, asynchronously.
// - Two scan links in series, one per processor core.
// - Serial data enters at TDI, passes each link, leaves at TDO.
// - Shared hard reset line low resets debug state of every device.
// - Test reset has an internal pull-up; board may pull it down.
// - Asserting the debug event input puts the cores into debug mode.
// - Second debug event pin outputs trigger pulses, e.g. for analyzers.
module djp_top (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       tck_i,
   input  wire logic       trst_n_i,
   input  wire logic       tms_i,
   input  wire logic       tdi_i,
   output logic            tdo_o,
   output logic            tdo_oe_o,
   input  wire logic       debug_event_in_i,
   output logic            debug_event_out_o,
   output logic            debug_event_out_oe_o,
   input  wire logic       hard_reset_n_i,
   output logic            hard_reset_n_o,
   output logic            hard_reset_n_oe_o,
   output logic [1:0]      debug_mode_o,
   output logic            trst_pullup_en_o
);
   // ***************************************************
   // Reset release on the system clock
   // ***************************************************
   logic [1:0] rst_sync_q;
   logic       rst_n;

   // Two stages so the release never lands near a clock edge
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_q <= djp_pkg::RST_SYNC;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ***************************************************
   // Scan links, one per core, chained in series
   // ***************************************************
   djp_pkg::djp_ctrl_type ctrl_w   [djp_pkg::CORES];
   djp_pkg::djp_stat_type stat_w   [djp_pkg::CORES];
   logic [2:0]            chain_w;
   logic [1:0]            link_oe_w;
   logic [1:0]            byp_w;

   assign chain_w[0] = tdi_i;
   // Each link gets the same clock and mode select in parallel
   for (genvar c = 0; c < 2; c++) begin : g_link
      djp_tap #(
         .ID (c == 0 ? djp_pkg::ID_CORE0 : djp_pkg::ID_CORE1)
      ) u_tap (
         .tck_i       (tck_i),
         .trst_n_i    (trst_n_i),
         .tms_i       (tms_i),
         .tdi_i       (chain_w[c]),
         .status_i    (stat_w[c]),
         .ctrl_o      (ctrl_w[c]),
         .tdo_o       (chain_w[c+1]),
         .tdo_oe_o    (link_oe_w[c]),
         .byp_shift_o (byp_w[c])
      );
   end
   // Last link output is itself the falling-edge flop
   assign tdo_o    = chain_w[2];
   assign tdo_oe_o = link_oe_w[1];

   // ***************************************************
   // Status into the test clock domain
   // ***************************************************
   logic [1:0] dbg_q, dbg_d;
   logic       hrst_f;
   logic [3:0] st_s1_q, st_s2_q;

   // Plain two-flop level crossing; the test clock may stop between scans
   always_ff @(posedge tck_i or negedge trst_n_i) begin
      if (!trst_n_i) begin
         st_s1_q <= 4'h0;
         st_s2_q <= 4'h0;
      end else begin
         st_s1_q <= {!hrst_f, dbg_q[1], !hrst_f, dbg_q[0]};
         st_s2_q <= st_s1_q;
      end
   end
   for (genvar c = 0; c < 2; c++) begin : g_stat
      assign stat_w[c] = {6'h00, st_s2_q[2*c+1], st_s2_q[2*c]};
   end

   // ***************************************************
   // Pin and control synchronisers on the system clock
   // ***************************************************
   logic [9:0] sy_in;
   logic [9:0] s1_q, s2_q, s3_q, f_q, fp_q;

   assign sy_in = {ctrl_w[1][3:0], ctrl_w[0][3:0], hard_reset_n_i, debug_event_in_i};
   // Three stages; a change counts only once the last two agree
   for (genvar b = 0; b < djp_pkg::SY_W; b++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[b] <= djp_pkg::SY_RST[b];
            s2_q[b] <= djp_pkg::SY_RST[b];
            s3_q[b] <= djp_pkg::SY_RST[b];
            f_q[b]  <= djp_pkg::SY_RST[b];
            fp_q[b] <= djp_pkg::SY_RST[b];
         end else begin
            s1_q[b] <= sy_in[b];
            s2_q[b] <= s1_q[b];
            s3_q[b] <= s2_q[b];
            f_q[b]  <= (s2_q[b] == s3_q[b]) ? s3_q[b] : f_q[b];
            fp_q[b] <= f_q[b];
         end
      end
   end
   assign hrst_f = f_q[djp_pkg::SY_HRST];

   // ***************************************************
   // Debug mode per core
   // ***************************************************
   logic       evt_rise;
   logic [1:0] halt_rise, resume_rise, trig_en, hreq;
   logic       enter;

   assign evt_rise = f_q[djp_pkg::SY_EVT] && !fp_q[djp_pkg::SY_EVT];
   for (genvar c = 0; c < 2; c++) begin : g_ctl
      localparam int unsigned B = djp_pkg::SY_CTRL + djp_pkg::SY_PER * c;
      assign halt_rise[c]   = f_q[B] && !fp_q[B];
      assign resume_rise[c] = f_q[B+1] && !fp_q[B+1];
      assign trig_en[c]     = f_q[B+2];
      assign hreq[c]        = f_q[B+3];
   end

   // Entry wins over a resume in the same cycle; hard reset clears all
   always_comb begin
      dbg_d = dbg_q;
      for (int c = 0; c < 2; c++) begin
         if (!hrst_f) begin
            dbg_d[c] = 1'b0;
         end else if (evt_rise || halt_rise[c]) begin
            dbg_d[c] = 1'b1;
         end else if (resume_rise[c]) begin
            dbg_d[c] = 1'b0;
         end
      end
   end
   assign enter = |(dbg_d & ~dbg_q);

   // ***************************************************
   // Trigger output and hard reset drive
   // ***************************************************
   logic [3:0] trig_cnt_q, trig_cnt_d;
   logic       trig_out_q, trig_out_d;
   logic       trig_oe_q, trig_oe_d;
   logic       hr_oe_q, hr_oe_d;

   // Fixed-width pulse per debug entry so a slow analyzer still sees it
   always_comb begin
      trig_cnt_d = trig_cnt_q;
      if (enter) begin
         trig_cnt_d = djp_pkg::TRIG_LOAD;
      end else if (trig_cnt_q != 4'h0) begin
         trig_cnt_d = trig_cnt_q - 4'h1;
      end
      trig_out_d = (trig_cnt_d != 4'h0);
      trig_oe_d  = |trig_en;
      hr_oe_d    = |hreq;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dbg_q      <= 2'h0;
         trig_cnt_q <= 4'h0;
         trig_out_q <= 1'b0;
         trig_oe_q  <= 1'b0;
         hr_oe_q    <= 1'b0;
         trst_pullup_en_o <= 1'b1;
      end else begin
         dbg_q      <= dbg_d;
         trig_cnt_q <= trig_cnt_d;
         trig_out_q <= trig_out_d;
         trig_oe_q  <= trig_oe_d;
         hr_oe_q    <= hr_oe_d;
         trst_pullup_en_o <= 1'b1;
      end
   end

   assign debug_mode_o         = dbg_q;
   assign debug_event_out_o    = trig_out_q;
   assign debug_event_out_oe_o = trig_oe_q;
   // Open drain: only ever pulls low
   assign hard_reset_n_o       = 1'b0;
   assign hard_reset_n_oe_o    = hr_oe_q;

   // ***************************************************
   // Checks
   // ***************************************************
   sequence both_bypass_s;
      byp_w[0] && byp_w[1];
   endsequence
   sequence entry_s;
      $rose(|dbg_q);
   endsequence

   chain_order_a: assert property (@(posedge tck_i) disable iff (!trst_n_i)
      both_bypass_s ##1 both_bypass_s |=> tdo_o == $past(tdi_i, 2)) else $error("chain does not pass data in series");
   link_state_a: assert property (@(posedge tck_i) disable iff (!trst_n_i)
      g_link[0].u_tap.state_q == g_link[1].u_tap.state_q) else $error("links left lockstep");
   debug_entry_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(f_q[djp_pkg::SY_EVT]) && hrst_f |=> debug_mode_o == 2'h3) else $error("event did not enter debug mode");
   trig_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      entry_s |-> debug_event_out_o [*8]) else $error("trigger pulse too short");
   trig_oe_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (trig_en == 2'h0) |=> !debug_event_out_oe_o) else $error("trigger pin driven while disabled");
   hard_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !hrst_f |=> debug_mode_o == 2'h0) else $error("hard reset did not clear debug mode");
   hr_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (hreq != 2'h0) |=> hard_reset_n_oe_o && !hard_reset_n_o) else $error("hard reset request not driven");
   pullup_on_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $past(rst_n) |-> trst_pullup_en_o) else $error("test reset pull-up disabled");
endmodule

// file: sim/djp_emu.sv
`timescale 1ns/1ps
// ***************************************************
// Emulator side of the test link
// ***************************************************
module djp_emu (
   output logic      tck_o,
   output logic      trst_n_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i
);
   // Test reset stays low through power-up until the bench lets go
   initial begin
      tck_o    = 1'b0;
      trst_n_o = 1'b0;
      tms_o    = 1'b1;
      tdi_o    = 1'b0;
   end

   // Test reset is asynchronous, so it may move while the clock stands still
   task automatic set_trst(input logic v);
      trst_n_o = v;
   endtask

   // One bit: lines move while the clock is low, output is taken just before the rise
   // Clock idles low between frames, it never runs free
   task automatic step(input logic m, input logic d, output logic o);
      tms_o = m;
      tdi_o = d;
      #80;
      o     = tdo_i;
      tck_o = 1'b1;
      #80;
      tck_o = 1'b0;
   endtask

   // Whole scan from idle back to idle; last bit leaves shift
   task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic o;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir) begin
         step(1'b1, 1'b0, o);
      end
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask
endmodule

// file: sim/dual_core_jtag_debug_port_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
// ***************************************************
// Bench top
// ***************************************************
module dual_core_jtag_debug_port_tb;
   logic        clk_i;
   logic        resetn_i;
   logic        tck, trst_n, tms, tdi, tdo, tdo_oe;
   logic        debug_event_in_i;
   logic        hrst_ext;
   logic        hrst_line;
   logic        ev_out, ev_oe, hrst_o, hrst_oe, pull_en;
   logic [1:0]  debug_mode_o;
   logic [63:0] dout;
   logic [31:0] rnd;
   logic        q[$];
   int          err_total;
   int          n_compared;
   int          hi;

   // Open-drain hard reset line with a pull-up; either side may pull it low
   assign hrst_line = (hrst_oe === 1'b1 || hrst_ext === 1'b0) ? 1'b0 : 1'b1;

   djp_emu u_djp_emu (.tck_o(tck), .trst_n_o(trst_n), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

   djp_top u_djp_top (
      .clk_i(clk_i), .resetn_i(resetn_i), .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms),
      .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .debug_event_in_i(debug_event_in_i),
      .debug_event_out_o(ev_out), .debug_event_out_oe_o(ev_oe), .hard_reset_n_i(hrst_line),
      .hard_reset_n_o(hrst_o), .hard_reset_n_oe_o(hrst_oe), .debug_mode_o(debug_mode_o),
      .trst_pullup_en_o(pull_en));

   // Clock generation
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic test_done;
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // IDCODE of both links, link nearest the output first
   task automatic chk_id;
      u_djp_emu.scan(1'b0, 64, 64'h0, dout);
      `CHK(dout, {djp_pkg::ID_CORE0, djp_pkg::ID_CORE1})
   endtask

   // Control word per link; link 1 bits enter first and travel furthest
   task automatic ctrl(input logic [7:0] c0, input logic [7:0] c1);
      u_djp_emu.scan(1'b0, 16, {48'h0, c0, c1}, dout);
   endtask

   task automatic settle;
      repeat (24) @(negedge clk_i);
   endtask

   // Hang guard, well beyond the few hundred test clocks the run needs
   initial begin
      #400000;
      err_total++;
      test_done();
   end

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      logic o;
      err_total        = 0;
      n_compared       = 0;
      rnd              = 32'hE6A093A2;
      resetn_i         = 1'b0;
      debug_event_in_i = 1'b0;
      hrst_ext         = 1'b1;
      repeat (12) @(negedge clk_i);
      resetn_i = 1'b1;
      settle();
      `CHK(pull_en, 1'b1)
      `CHK(tdo_oe, 1'b0)
      `CHK(debug_mode_o, 2'b00)
      #3;
      u_djp_emu.set_trst(1'b1);
      u_djp_emu.step(1'b0, 1'b0, o);
      // Instruction capture, then load IDCODE into both links
      u_djp_emu.scan(1'b1, 8, 64'h11, dout);
      `CHK(dout[7:0], {djp_pkg::IR_CAPTURE, djp_pkg::IR_CAPTURE})
      chk_id();
      // Both links in bypass: random data comes out two bits late
      u_djp_emu.scan(1'b1, 8, 64'hFF, dout);
      rnd = xs(rnd);
      q = {1'b0, 1'b0};
      for (int i = 0; i < 32; i++) begin
         q.push_back(rnd[i]);
      end
      u_djp_emu.scan(1'b0, 34, {32'h0, rnd}, dout);
      for (int i = 0; i < 34; i++) begin
         `CHK(dout[i], q.pop_front())
      end
      // Test reset in mid-shift with the test clock standing still
      u_djp_emu.step(1'b1, 1'b0, o);
      u_djp_emu.step(1'b0, 1'b0, o);
      u_djp_emu.step(1'b0, 1'b0, o);
      #1;
      `CHK(tdo_oe, 1'b1)
      u_djp_emu.set_trst(1'b0);
      #1;
      `CHK(tdo_oe, 1'b0)
      `CHK(tdo, 1'b0)
      // A test clock edge under test reset must leave the controller initialised
      u_djp_emu.step(1'b1, 1'b0, o);
      u_djp_emu.set_trst(1'b1);
      u_djp_emu.step(1'b0, 1'b0, o);
      chk_id();
      // Enable trigger output on both cores
      u_djp_emu.scan(1'b1, 8, 64'h88, dout);
      ctrl(8'h04, 8'h04);
      settle();
      `CHK(ev_oe, 1'b1)
      // Debug event enters both cores and fires one trigger pulse
      @(negedge clk_i);
      debug_event_in_i = 1'b1;
      hi = 0;
      for (int k = 0; k < 40; k++) begin
         @(negedge clk_i);
         hi += (ev_out === 1'b1);
      end
      `CHK(debug_mode_o, 2'b11)
      `CHK(hi, int'(djp_pkg::TRIG_CYC))
      ctrl(8'h04, 8'h04);
      `CHK({dout[8], dout[0]}, 2'b11)
      // Link 1 asks for hard reset; the shared line clears both cores
      ctrl(8'h04, 8'h0C);
      settle();
      `CHK(hrst_oe, 1'b1)
      `CHK(hrst_o, 1'b0)
      `CHK(debug_mode_o, 2'b00)
      ctrl(8'h04, 8'h04);
      `CHK({dout[9], dout[1]}, 2'b11)
      // Five mode-select highs return both links to reset, instruction back to IDCODE
      for (int i = 0; i < 5; i++) begin
         u_djp_emu.step(1'b1, 1'b0, o);
      end
      u_djp_emu.step(1'b0, 1'b0, o);
      chk_id();
      settle();
      `CHK(hrst_oe, 1'b0)
      `CHK(ev_oe, 1'b0)
      test_done();
   end
endmodule
